// ===== core/plmc_mode_decode.sv
// purely combinational decode of the interface mode and framing mode fields
// assumes its inputs come from registers on the same clock
`timescale 1ns/1ns
module plmc_mode_decode (
    plmc_mode_if.dec m
);

    // ************************************************************
    // interface mode decode
    // ************************************************************
    // any 1xx code is unipolar with everything off, so bit 2 dominates
    always_comb begin
        m.unit_on = 1'b0;
        m.atten_on = 1'b0;
        m.atten_in_tx_path = 1'b0;
        if (!m.interface_mode_sel[2]) begin
            unique case (m.interface_mode_sel)
                plmc_pkg::IFM_UNIT_OFF: begin
                    m.unit_on = 1'b0;
                end
                plmc_pkg::IFM_UNIT_ON: begin
                    m.unit_on = 1'b1;
                end
                plmc_pkg::IFM_ATTEN_TX: begin
                    m.unit_on = 1'b1;
                    m.atten_on = 1'b1;
                    m.atten_in_tx_path = 1'b1;
                end
                plmc_pkg::IFM_ATTEN_RX: begin
                    m.unit_on = 1'b1;
                    m.atten_on = 1'b1;
                end
                default: begin
                    m.unit_on = 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // line code and framing family
    // ************************************************************
    // ami needs both suppress-disable flags; one alone keeps zero suppression
    always_comb begin
        if (m.interface_mode_sel[2]) begin
            m.line_code = plmc_pkg::PLMC_CODE_UNI;
        end else if (m.tx_zero_suppress_disable && m.rx_zero_suppress_disable) begin
            m.line_code = plmc_pkg::PLMC_CODE_AMI;
        end else begin
            m.line_code = plmc_pkg::PLMC_CODE_ZS;
        end
        m.ds3_framing = (m.framing_mode_sel == plmc_pkg::FRM_DS3_CBIT)
            || (m.framing_mode_sel == plmc_pkg::FRM_DS3_M23)
            || (m.framing_mode_sel == plmc_pkg::FRM_DS3_UNFRAMED);
    end

endmodule : plmc_mode_decode

// ===== core/plmc_mode_if.sv
// interface carrying the mode fields to the decoder and the decoded controls back
// assumes both ends run on the same register clock; all signals are plain levels
`timescale 1ns/1ns
interface plmc_mode_if;
    logic [2:0] interface_mode_sel;
    logic [2:0] framing_mode_sel;
    logic tx_zero_suppress_disable;
    logic rx_zero_suppress_disable;
    logic unit_on;
    logic atten_on;
    logic atten_in_tx_path;
    logic ds3_framing;
    plmc_pkg::plmc_line_code_t line_code;

    modport dec (
        input interface_mode_sel,
        input framing_mode_sel,
        input tx_zero_suppress_disable,
        input rx_zero_suppress_disable,
        output unit_on,
        output atten_on,
        output atten_in_tx_path,
        output ds3_framing,
        output line_code
    );

    modport top (
        output interface_mode_sel,
        output framing_mode_sel,
        output tx_zero_suppress_disable,
        output rx_zero_suppress_disable,
        input unit_on,
        input atten_on,
        input atten_in_tx_path,
        input ds3_framing,
        input line_code
    );
endinterface : plmc_mode_if

// ===== core/plmc_pkg.sv
// package for the port line mode control block: register map, field layout, codes
// assumes a single 20 MHz register clock and a plain address/strobe register port
package plmc_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] PORT_LINE_CONTROL_TWO_OFS = 8'h42;
    localparam logic [15:0] PORT_LINE_CONTROL_TWO_RST = 16'h0000;
    // writable bits; reserved bits 11, 7:6 and 2:0 stay zero
    localparam logic [15:0] PORT_LINE_CONTROL_TWO_WMASK = 16'hf738;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned TX_LINE_OUTPUT_ENABLE_BIT = 15;
    localparam int unsigned TX_ANALOG_TRISTATE_BIT = 14;
    localparam int unsigned RX_MONITOR_PREAMP_ENABLE_BIT = 13;
    localparam int unsigned TX_BUILDOUT_ENABLE_BIT = 12;
    localparam int unsigned INTERFACE_MODE_LSB = 8;
    localparam int unsigned FRAMING_MODE_LSB = 3;

    // ************************************************************
    // interface mode codes
    // ************************************************************
    localparam logic [2:0] IFM_UNIT_OFF = 3'h0;
    localparam logic [2:0] IFM_UNIT_ON = 3'h1;
    localparam logic [2:0] IFM_ATTEN_TX = 3'h2;
    localparam logic [2:0] IFM_ATTEN_RX = 3'h3;

    // ************************************************************
    // framing mode codes
    // ************************************************************
    localparam logic [2:0] FRM_DS3_CBIT = 3'h0;
    localparam logic [2:0] FRM_DS3_M23 = 3'h1;
    localparam logic [2:0] FRM_E3_G751 = 3'h2;
    localparam logic [2:0] FRM_E3_G832 = 3'h3;
    localparam logic [2:0] FRM_DS3_UNFRAMED = 3'h4;
    localparam logic [2:0] FRM_E3_UNFRAMED = 3'h6;

    typedef enum logic [1:0] {
        PLMC_CODE_ZS = 2'h0,  // b3zs on ds3, hdb3 on e3
        PLMC_CODE_AMI = 2'h1,
        PLMC_CODE_UNI = 2'h2
    } plmc_line_code_t;

    // ************************************************************
    // whole state of the register bank
    // ************************************************************
    typedef struct packed {
        logic tx_line_output_enable;
        logic tx_analog_tristate;
        logic rx_monitor_preamp_enable;
        logic tx_buildout_enable;
        logic [2:0] interface_mode_sel;
        logic [2:0] framing_mode_sel;
        logic [15:0] rdata;
    } plmc_state_t;

endpackage : plmc_pkg

// ===== core/plmc_port_line_mode_control.sv
// port line mode control register bank and the line-side gating it drives
// assumes a host on a plain address/strobe port and framer/zero-suppress inputs on clk
//
// Behaviour
// - bit 15 clear forces line clock, pos/data and neg outputs low; set passes them
// - bit 14 set tri-states both analog transmit pins; clear drives them
// - the tri-state bit does nothing while the line interface is powered down
// - bit 13 enables the roughly 20 dB receive monitor pre-amplifier
// - bit 12 enables 225 foot build-out shaping, effective only in ds3 mode
// - interface mode field sits in bits 10:8, reset leaves interface and attenuator off
// - mode 000 off, 001 on, 010 attenuator tx, 011 attenuator rx, 1xx unipolar off
// - modes 000-011 use b3zs/hdb3, or ami when suppress-disable flags are set
// - framing field bits 5:3, resets to ds3 c-bit, 101 and 111 undefined
`timescale 1ns/1ns
module plmc_port_line_mode_control #(
    parameter int unsigned ADDR_W = plmc_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic tx_zero_suppress_disable,
    input wire logic rx_zero_suppress_disable,
    input wire logic tx_line_clock_in,
    input wire logic tx_line_pos_data_in,
    input wire logic tx_line_neg_in,
    output logic tx_line_clock_out,
    output logic tx_line_pos_data,
    output logic tx_line_neg,
    output logic tx_analog_oe,
    output logic rx_monitor_preamp_enable,
    output logic tx_buildout_enable,
    output logic line_interface_unit_power,
    output logic jitter_attenuator_enable,
    output logic jitter_attenuator_in_tx_path,
    output logic [1:0] line_code,
    output logic [2:0] framing_mode_sel
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // the register offset needs seven address bits
    if (ADDR_W < 7) begin : g_addr_check
        $error("plmc: ADDR_W too small for the register offset");
    end

    // ************************************************************
    // helpers
    // ************************************************************
    // register image as software sees it; reserved bits fall out as zero
    function automatic logic [15:0] plmc_image(input plmc_pkg::plmc_state_t s);
        logic [15:0] v;
        v = 16'h0000;
        v[plmc_pkg::TX_LINE_OUTPUT_ENABLE_BIT] = s.tx_line_output_enable;
        v[plmc_pkg::TX_ANALOG_TRISTATE_BIT] = s.tx_analog_tristate;
        v[plmc_pkg::RX_MONITOR_PREAMP_ENABLE_BIT] = s.rx_monitor_preamp_enable;
        v[plmc_pkg::TX_BUILDOUT_ENABLE_BIT] = s.tx_buildout_enable;
        v[plmc_pkg::INTERFACE_MODE_LSB +: 3] = s.interface_mode_sel;
        v[plmc_pkg::FRAMING_MODE_LSB +: 3] = s.framing_mode_sel;
        return v;
    endfunction : plmc_image

    function automatic logic plmc_hit(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(plmc_pkg::PORT_LINE_CONTROL_TWO_OFS);
    endfunction : plmc_hit

    // ************************************************************
    // state
    // ************************************************************
    plmc_pkg::plmc_state_t state_r;
    plmc_pkg::plmc_state_t state_nxt;
    logic [15:0] wval;

    // write merge and read capture; the host never waits
    always_comb begin
        state_nxt = state_r;
        wval = reg_wdata & plmc_pkg::PORT_LINE_CONTROL_TWO_WMASK;
        if (reg_wr && plmc_hit(reg_addr)) begin
            state_nxt.tx_line_output_enable = wval[plmc_pkg::TX_LINE_OUTPUT_ENABLE_BIT];
            state_nxt.tx_analog_tristate = wval[plmc_pkg::TX_ANALOG_TRISTATE_BIT];
            state_nxt.rx_monitor_preamp_enable = wval[plmc_pkg::RX_MONITOR_PREAMP_ENABLE_BIT];
            state_nxt.tx_buildout_enable = wval[plmc_pkg::TX_BUILDOUT_ENABLE_BIT];
            state_nxt.interface_mode_sel = wval[plmc_pkg::INTERFACE_MODE_LSB +: 3];
            state_nxt.framing_mode_sel = wval[plmc_pkg::FRAMING_MODE_LSB +: 3];
        end
        // read data stand for exactly the cycle after the strobe
        if (reg_rd && plmc_hit(reg_addr)) begin
            state_nxt.rdata = plmc_image(state_r);
        end else begin
            state_nxt.rdata = 16'h0000;  // unmapped or idle reads return zero
        end
    end

    // everything resets to zero: line interface off, ds3 c-bit framing
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign reg_rdata = state_r.rdata;

    // ************************************************************
    // mode decode
    // ************************************************************
    plmc_mode_if mode_if ();

    assign mode_if.interface_mode_sel = state_r.interface_mode_sel;
    assign mode_if.framing_mode_sel = state_r.framing_mode_sel;
    assign mode_if.tx_zero_suppress_disable = tx_zero_suppress_disable;
    assign mode_if.rx_zero_suppress_disable = rx_zero_suppress_disable;

    plmc_mode_decode u_decode (
        .m(mode_if.dec)
    );

    // ************************************************************
    // line side outputs
    // ************************************************************
    // gating stays combinational so the line clock keeps its own edges
    assign tx_line_clock_out = tx_line_clock_in & state_r.tx_line_output_enable;
    assign tx_line_pos_data = tx_line_pos_data_in & state_r.tx_line_output_enable;
    assign tx_line_neg = tx_line_neg_in & state_r.tx_line_output_enable;

    // a powered-down interface drives nothing, whatever the tri-state bit says
    assign tx_analog_oe = mode_if.unit_on & ~state_r.tx_analog_tristate;
    assign rx_monitor_preamp_enable = state_r.rx_monitor_preamp_enable;
    // build-out has no meaning for e3 pulses or with the interface off
    assign tx_buildout_enable = state_r.tx_buildout_enable & mode_if.unit_on
        & mode_if.ds3_framing;
    assign line_interface_unit_power = mode_if.unit_on;
    assign jitter_attenuator_enable = mode_if.atten_on;
    assign jitter_attenuator_in_tx_path = mode_if.atten_in_tx_path;
    assign line_code = mode_if.line_code;
    assign framing_mode_sel = state_r.framing_mode_sel;

endmodule : plmc_port_line_mode_control

// ===== testbench/plmc_host_model.sv
// host processor model driving the register port of the block
// assumes one call of op per cycle; every call changes all signals at one edge
`timescale 1ns/1ns
module plmc_host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // idle bus from time zero so nothing is taken during reset
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one bus cycle; data passes as given, so keeping reserved bits zero is the caller's job
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : op
endmodule : plmc_host_model

// ===== testbench/plmc_port_line_mode_control_assertions.sv
// checker for the port line mode control block, watching only its top ports
// assumes a bind from the bench top, one clk domain and a synchronous rst
`timescale 1ns/1ns
module plmc_port_line_mode_control_assertions #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic tx_zero_suppress_disable,
    input wire logic rx_zero_suppress_disable,
    input wire logic tx_line_clock_in,
    input wire logic tx_line_clock_out,
    input wire logic tx_analog_oe,
    input wire logic rx_monitor_preamp_enable,
    input wire logic tx_buildout_enable,
    input wire logic line_interface_unit_power,
    input wire logic jitter_attenuator_enable,
    input wire logic jitter_attenuator_in_tx_path,
    input wire logic [1:0] line_code,
    input wire logic [2:0] framing_mode_sel
);
    // ********
    // shadow register rebuilt from the write port
    // ********
    logic [15:0] shadow_r;
    logic [2:0] mode_code;
    logic unit_on;
    // reserved bits never reach the shadow, so read-back checks cover them as well
    always_ff @(posedge clk) begin
        if (rst) begin
            shadow_r <= 16'h0000;
        end else if (reg_wr && reg_addr == 8'h42) begin
            shadow_r <= reg_wdata & 16'hf738;
        end
    end
    assign mode_code = shadow_r[10:8];
    assign unit_on = (mode_code != 3'h0) && !mode_code[2];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence map_wr;
        reg_wr && reg_addr == 8'h42;
    endsequence
    sequence map_rd;
        reg_rd && reg_addr == 8'h42;
    endsequence
    line_gate_a: assert property (
        tx_line_clock_out == (tx_line_clock_in & shadow_r[15]))
        else $error("line clock gating wrong");
    tristate_a: assert property (tx_analog_oe == (unit_on && !shadow_r[14]))
        else $error("analog enable wrong");
    preamp_a: assert property (
        map_wr |=> rx_monitor_preamp_enable == $past(reg_wdata[13]))
        else $error("preamp enable wrong");
    buildout_a: assert property (tx_buildout_enable ==
        (shadow_r[12] && unit_on && shadow_r[5:3] inside {3'h0, 3'h1, 3'h4}))
        else $error("buildout wrong");
    mode_a: assert property (line_interface_unit_power == unit_on
        && jitter_attenuator_enable == (mode_code == 3'h2 || mode_code == 3'h3))
        else $error("mode decode wrong");
    ja_path_a: assert property (jitter_attenuator_in_tx_path == (mode_code == 3'h2))
        else $error("attenuator path wrong");
    line_code_a: assert property (line_code == (mode_code[2] ? 2'h2 :
        {1'b0, tx_zero_suppress_disable && rx_zero_suppress_disable}))
        else $error("line code wrong");
    framing_a: assert property (
        map_wr |=> framing_mode_sel == $past(reg_wdata[5:3]))
        else $error("framing field wrong");
    read_back_a: assert property (map_rd |=> reg_rdata == $past(shadow_r))
        else $error("read data wrong");
    rdata_idle_a: assert property (
        !$past(reg_rd && reg_addr == 8'h42) |-> reg_rdata == 16'h0000)
        else $error("read data not zero");
endmodule : plmc_port_line_mode_control_assertions

// ===== testbench/plmc_port_line_mode_control_tb.sv
// bench top: sweeps every mode code with random data and checks controls and read-back
// assumes the host model owns the register port; this file drives all other inputs
`timescale 1ns/1ns
module plmc_port_line_mode_control_tb;
    logic clk, rst, reg_wr, reg_rd, rd_d;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic tx_zero_suppress_disable, rx_zero_suppress_disable, tx_line_clock_in;
    logic tx_line_pos_data_in, tx_line_neg_in, tx_line_clock_out, tx_line_pos_data;
    logic tx_line_neg, tx_analog_oe, rx_monitor_preamp_enable, tx_buildout_enable;
    logic line_interface_unit_power, jitter_attenuator_enable, jitter_attenuator_in_tx_path;
    logic [1:0] line_code;
    logic [2:0] framing_mode_sel;
    logic [15:0] exp_q[$];
    int fails = 0;
    int comparisons = 0;
    int seed = 18040;
    plmc_port_line_mode_control plmc_port_line_mode_control_i (.*);
    plmc_host_model plmc_host_model_i (.*);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        plmc_host_model_i.op(1'b0, 1'b1, a, 16'h0000);
        exp_q.push_back(exp);
    endtask : rd
    // expected controls worked out from register word w, the flags and the line inputs
    task automatic chk_out(input logic [15:0] w);
        logic [2:0] mode_code;
        logic unit_on;
        mode_code = w[10:8];
        unit_on = (mode_code != 3'h0) && !mode_code[2];
        @(negedge clk);
        chk({2'b00, tx_line_clock_out, tx_line_pos_data, tx_line_neg, tx_analog_oe,
            rx_monitor_preamp_enable, tx_buildout_enable, line_interface_unit_power,
            jitter_attenuator_enable, jitter_attenuator_in_tx_path, line_code, framing_mode_sel},
            {2'b00, {tx_line_clock_in, tx_line_pos_data_in, tx_line_neg_in} & {3{w[15]}},
            unit_on & !w[14], w[13], w[12] & unit_on & (w[5:3] inside {3'h0, 3'h1, 3'h4}),
            unit_on, mode_code == 3'h2 || mode_code == 3'h3, mode_code == 3'h2,
            mode_code[2] ? 2'h2 : {1'b0, tx_zero_suppress_disable & rx_zero_suppress_disable},
            w[5:3]});
    endtask : chk_out
    // a read is taken at one edge and answered until the next, so compare mid-cycle
    always @(posedge clk) rd_d <= reg_rd && !rst;
    always @(negedge clk) begin
        if (rd_d) begin
            chk(reg_rdata, exp_q.pop_front());
        end
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        conclude();
    end
    initial begin
        logic [31:0] r;
        logic [15:0] w;
        rst = 1'b1;
        {tx_zero_suppress_disable, rx_zero_suppress_disable} = 2'b00;
        {tx_line_clock_in, tx_line_pos_data_in, tx_line_neg_in} = 3'b111;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(8'h42, 16'h0000);
        chk_out(16'h0000);
        // mode and framing codes from the index, control bits random, reserved bits zero;
        // undefined framing codes 101 and 111 fold onto 100 and 110, as software must
        for (int i = 0; i < 64; i++) begin
            r = $random(seed);
            w = {r[15:12], 1'b0, i[2:0], 2'b00, i[5:4], i[3] & !i[5], 3'b000};
            plmc_host_model_i.op(1'b1, 1'b0, 8'h42, w);
            {tx_zero_suppress_disable, rx_zero_suppress_disable} <= {i[3], i[4] | r[20]};
            {tx_line_clock_in, tx_line_pos_data_in, tx_line_neg_in} <= r[19:17];
            rd(8'h42, w & 16'hf738);
            chk_out(w);
        end
        // unmapped write is dropped and an unmapped read answers zero
        plmc_host_model_i.op(1'b1, 1'b0, 8'h43, 16'hffff);
        rd(8'h42, w & 16'hf738);
        rd(8'h43, 16'h0000);
        plmc_host_model_i.op(1'b0, 1'b0, 8'h00, 16'h0000);
        // reset in mid-run clears everything again
        @(posedge clk);
        rst <= 1'b1;
        {tx_zero_suppress_disable, rx_zero_suppress_disable} <= 2'b00;
        @(posedge clk);
        rst <= 1'b0;
        rd(8'h42, 16'h0000);
        chk_out(16'h0000);
        plmc_host_model_i.op(1'b0, 1'b0, 8'h00, 16'h0000);
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule : plmc_port_line_mode_control_tb
bind plmc_port_line_mode_control plmc_port_line_mode_control_assertions #(.ADDR_W(ADDR_W)) chk_i (.*);
